// file: hdl/acsd_regs.vh
`ifndef ACSD_REGS_VH
`define ACSD_REGS_VH
// register byte addresses (8-bit address port)
`define ACSD_ADDR_SCAN_CTRL 8'h10
`define ACSD_ADDR_PIN_ROLE 8'h05
`define ACSD_ADDR_MANUAL_PICK 8'h11
`define ACSD_ADDR_SCAN_MEMBER 8'h12
`define ACSD_ADDR_TEST_UNLOCK 8'hbf
`define ACSD_ADDR_TEST_CTRL 8'hc0
`define ACSD_ADDR_FORCED_LOW 8'hc1
`define ACSD_ADDR_FORCED_HIGH 8'hc2
// reset values
`define ACSD_RST_BYTE 8'h00
// field positions and masks
`define ACSD_MANUAL_ID_MASK 8'h0f
`define ACSD_TEST_CTRL_MASK 8'h11
`define ACSD_SCAN_CTRL_MASK 8'h13
`define ACSD_BIT_WALK 0
`define ACSD_BIT_VROUTE 4
`define ACSD_BIT_SCAN_GO 4
// unlock key
`define ACSD_UNLOCK_CODE 8'h96
// scan schemes
`define ACSD_SCHEME_MANUAL 2'b00
`define ACSD_SCHEME_AUTO 2'b01
`define ACSD_SCHEME_OTF 2'b10
// sequencer dwell count per channel; each channel holds for this value plus one cycles
`define ACSD_DWELL_CYCLES 8'h07
`endif

// file: hdl/acsd_chan_diag.v
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "acsd_regs.vh"
module acsd_chan_diag (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire diagnostic_gate_i,
  input wire otf_valid_i,
  input wire [2:0] otf_input_id_i,
  output reg [7:0] rdata_o,
  output reg [2:0] conv_input_id_o,
  output reg conv_input_valid_o,
  output reg [7:0] pin_role_o,
  output reg internal_test_voltage_route_o,
  output reg decision_walk_enable_o,
  output reg [15:0] forced_pattern_o,
  output reg forced_pattern_en_o
);

  // register map, every byte resets to zero:
  //   05 pin role mask, one bit per channel
  //   10 scan control: scheme in bits 1..0, scan go in bit 4, bit 3 reads the run flag
  //   11 manual pick, low nibble only
  //   12 scan membership mask
  //   bf unlock key, kept as written
  //   c0 test controls: walk in bit 0, test voltage route in bit 4
  //   c1 forced pattern bits 7..0
  //   c2 forced pattern bits 15..8
  // c0..c2 keep their value when written without the key; nothing is flagged,
  // so a host that needs to know must read back

  // host-visible register copies
  reg [7:0] manual_pick_q;
  reg [7:0] scan_member_q;
  reg [7:0] test_unlock_q;
  reg [7:0] test_ctrl_q;
  reg [7:0] forced_low_q;
  reg [7:0] forced_high_q;
  reg [7:0] scan_ctrl_q;
  reg [7:0] pin_role_q;
  // sequencer position, dwell counter and run flag
  reg [2:0] scan_pos_q;
  reg [2:0] scan_pos_d;
  reg scan_hit_d;
  reg [7:0] dwell_q;
  reg scan_run_q;
  integer k;

  // decoded control fields
  wire unlocked = (test_unlock_q == `ACSD_UNLOCK_CODE);
  wire [1:0] scheme = scan_ctrl_q[1:0];
  wire scan_go = scan_ctrl_q[`ACSD_BIT_SCAN_GO];
  wire walk_en = test_ctrl_q[`ACSD_BIT_WALK];

  // one-hot write strobe for a given address
  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    input w;
    begin
      wr_hit = w && (a == target);
    end
  endfunction

  // per-register write strobes; the three diagnostic ones also need the key
  wire we_manual = wr_hit(addr_i, `ACSD_ADDR_MANUAL_PICK, wr_i);
  wire we_member = wr_hit(addr_i, `ACSD_ADDR_SCAN_MEMBER, wr_i);
  wire we_unlock = wr_hit(addr_i, `ACSD_ADDR_TEST_UNLOCK, wr_i);
  wire we_scan_ctrl = wr_hit(addr_i, `ACSD_ADDR_SCAN_CTRL, wr_i);
  wire we_pin_role = wr_hit(addr_i, `ACSD_ADDR_PIN_ROLE, wr_i);
  // a write in the same cycle as the key write still sees the old key
  wire we_test_ctrl = unlocked && wr_hit(addr_i, `ACSD_ADDR_TEST_CTRL, wr_i);
  wire we_forced_low = unlocked && wr_hit(addr_i, `ACSD_ADDR_FORCED_LOW, wr_i);
  wire we_forced_high = unlocked && wr_hit(addr_i, `ACSD_ADDR_FORCED_HIGH, wr_i);

  // manual pick; only the low nibble stores, the reserved top reads zero
  // a reserved id with bit 3 set still stores and turns the pick invalid
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      manual_pick_q <= `ACSD_RST_BYTE;
    end else if (we_manual) begin
      manual_pick_q <= wdata_i & `ACSD_MANUAL_ID_MASK;
    end
  end

  // scan membership mask, all eight bits live
  // a change while scanning takes effect at the next step
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scan_member_q <= `ACSD_RST_BYTE;
    end else if (we_member) begin
      scan_member_q <= wdata_i;
    end
  end

  // unlock key, kept as written rather than self-clearing
  // so one key write opens the diagnostic block until rewritten
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      test_unlock_q <= `ACSD_RST_BYTE;
    end else if (we_unlock) begin
      test_unlock_q <= wdata_i;
    end
  end

  // scan control; bits 4, 1 and 0 store, bit 3 is the run flag on readback
  // clearing scan go stops the sequencer at the next edge
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scan_ctrl_q <= `ACSD_RST_BYTE;
    end else if (we_scan_ctrl) begin
      scan_ctrl_q <= wdata_i & `ACSD_SCAN_CTRL_MASK;
    end
  end

  // pin role mask, one bit per channel, set for general-purpose i/o
  // no interlock with the manual pick; keeping it analog is the host's job
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_role_q <= `ACSD_RST_BYTE;
    end else if (we_pin_role) begin
      pin_role_q <= wdata_i;
    end
  end

  // test controls; only the walk and route bits store
  // locked writes are dropped silently
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      test_ctrl_q <= `ACSD_RST_BYTE;
    end else if (we_test_ctrl) begin
      test_ctrl_q <= wdata_i & `ACSD_TEST_CTRL_MASK;
    end
  end

  // forced pattern low byte, behind the key
  // keeps its value while the gate is low, it only stops reaching the output
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      forced_low_q <= `ACSD_RST_BYTE;
    end else if (we_forced_low) begin
      forced_low_q <= wdata_i;
    end
  end

  // forced pattern high byte, behind the key
  // written separately, so the two halves may briefly disagree
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      forced_high_q <= `ACSD_RST_BYTE;
    end else if (we_forced_high) begin
      forced_high_q <= wdata_i;
    end
  end

  // read port, data valid the cycle after the strobe; unmapped reads zero
  // rdata falls back to zero when no read is pending, so the host
  // must take it in exactly that one cycle
  // scan control shows the live run flag in bit 3 rather than a stored bit
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= `ACSD_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        `ACSD_ADDR_MANUAL_PICK: rdata_o <= manual_pick_q;
        `ACSD_ADDR_SCAN_MEMBER: rdata_o <= scan_member_q;
        `ACSD_ADDR_TEST_UNLOCK: rdata_o <= test_unlock_q;
        `ACSD_ADDR_TEST_CTRL: rdata_o <= test_ctrl_q;
        `ACSD_ADDR_FORCED_LOW: rdata_o <= forced_low_q;
        `ACSD_ADDR_FORCED_HIGH: rdata_o <= forced_high_q;
        `ACSD_ADDR_SCAN_CTRL: rdata_o <= {scan_ctrl_q[7:4], scan_run_q, scan_ctrl_q[2:0]};
        `ACSD_ADDR_PIN_ROLE: rdata_o <= pin_role_q;
        default: rdata_o <= `ACSD_RST_BYTE;
      endcase
    end else begin
      rdata_o <= `ACSD_RST_BYTE;
    end
  end

  // next enabled member above the current position, wrapping to the lowest
  // the loop runs downwards so the nearest member wins
  // from the rewind position 7 the first pick is the lowest member
  // scan_hit_d tells whether any member is enabled at all
  // an empty mask holds the sequencer idle
  always @* begin
    scan_pos_d = scan_pos_q;
    scan_hit_d = 1'b0;
    for (k = 7; k >= 1; k = k - 1) begin
      if (scan_member_q[(scan_pos_q + k[2:0]) & 3'h7] ) begin
        scan_pos_d = scan_pos_q + k[2:0];
        scan_hit_d = 1'b1;
      end
    end
    if (!scan_hit_d && scan_member_q[scan_pos_q]) begin
      scan_hit_d = 1'b1;
    end
  end

  // automatic sequencer; dwells a fixed time per input before stepping
  // the first cycle of a run steps at once, so the lowest member is
  // offered without waiting a full dwell
  // the dwell is fixed, not tied to the converter's own cycle
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scan_pos_q <= 3'h7;
      dwell_q <= `ACSD_RST_BYTE;
      scan_run_q <= 1'b0;
    end else if (scheme == `ACSD_SCHEME_AUTO && scan_go && scan_hit_d) begin
      scan_run_q <= 1'b1;
      if (!scan_run_q || dwell_q == `ACSD_DWELL_CYCLES) begin
        scan_pos_q <= scan_pos_d;
        dwell_q <= `ACSD_RST_BYTE;
      end else begin
        dwell_q <= dwell_q + 8'h01;
      end
    end else begin
      // stopping rewinds so the next start begins at the lowest member
      scan_run_q <= 1'b0;
      scan_pos_q <= 3'h7;
      dwell_q <= `ACSD_RST_BYTE;
    end
  end

  // input selection per scheme; reserved scheme 11 never offers a valid pick
  // every output lags its register by one cycle
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      conv_input_id_o <= 3'h0;
      conv_input_valid_o <= 1'b0;
    end else begin
      case (scheme)
        `ACSD_SCHEME_MANUAL: begin
          conv_input_id_o <= manual_pick_q[2:0];
          // reserved ids left to the host; only 0..7 give a valid pick
          conv_input_valid_o <= ~manual_pick_q[3];
        end
        `ACSD_SCHEME_AUTO: begin
          // the position only counts while the sequencer runs
          conv_input_id_o <= scan_pos_q;
          conv_input_valid_o <= scan_run_q;
        end
        `ACSD_SCHEME_OTF: begin
          // on-the-fly id passes straight through, one cycle late
          conv_input_id_o <= otf_input_id_i;
          conv_input_valid_o <= otf_valid_i;
        end
        default: begin
          conv_input_id_o <= 3'h0;
          conv_input_valid_o <= 1'b0;
        end
      endcase
    end
  end

  // pin roles for the pad logic
  // a scanned channel still converts if its pin is i/o; the host must avoid that
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_role_o <= `ACSD_RST_BYTE;
    end else begin
      pin_role_o <= pin_role_q;
    end
  end

  // walk mode and test voltage route
  // walk wins, so the route never disturbs a bit-walk run
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      decision_walk_enable_o <= 1'b0;
      internal_test_voltage_route_o <= 1'b0;
    end else begin
      decision_walk_enable_o <= walk_en;
      internal_test_voltage_route_o <= test_ctrl_q[`ACSD_BIT_VROUTE] & ~walk_en;
    end
  end

  // forced pattern, zero while the gate is low
  // so a stale pattern never reaches the converter
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      forced_pattern_en_o <= 1'b0;
      forced_pattern_o <= 16'h0000;
    end else begin
      forced_pattern_en_o <= diagnostic_gate_i;
      forced_pattern_o <= diagnostic_gate_i ? {forced_high_q, forced_low_q} : 16'h0000;
    end
  end

endmodule

// file: test/acsd_chk_assertions.sv
`timescale 1ns/10ps
module acsd_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic diagnostic_gate_i,
  input wire logic forced_pattern_en_o,
  input wire logic decision_walk_enable_o,
  input wire logic internal_test_voltage_route_o,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] forced_pattern_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // key write, then a control write two cycles on; the output shows it two edges after that write
  sequence s_key_bad; wr_i && addr_i == 8'hbf && wdata_i != 8'h96; endsequence
  sequence s_key_ok; wr_i && addr_i == 8'hbf && wdata_i == 8'h96; endsequence
  sequence s_c0_wr; wr_i && addr_i == 8'hc0; endsequence
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
  AST_PICK_RSV: assert property (rd_i && addr_i == 8'h11 |=> rdata_o[7:4] == 4'h0) else $error("pick top set");
  AST_DIAG_RSV: assert property (rd_i && addr_i == 8'hc0 |=> (rdata_o & 8'hee) == 8'h00) else $error("c0 rsv");
  AST_GATE_OFF: assert property (!forced_pattern_en_o |-> forced_pattern_o == 16'h0000) else $error("pattern leak");
  AST_GATE_FOLLOW: assert property (diagnostic_gate_i |=> forced_pattern_en_o) else $error("gate lost");
  AST_WALK_MASK: assert property (decision_walk_enable_o |-> !internal_test_voltage_route_o) else $error("route on");
  AST_LOCKED: assert property (s_key_bad ##2 s_c0_wr |-> ##2 $stable(decision_walk_enable_o))
    else $error("locked write took");
  AST_UNLOCKED: assert property (s_key_ok ##2 s_c0_wr |-> ##2 decision_walk_enable_o == $past(wdata_i[0], 2))
    else $error("unlocked write lost");
endmodule
bind acsd_chan_diag acsd_chk u_acsd_chk (.mclk_i, .rst_n_i, .wr_i, .rd_i, .diagnostic_gate_i, .forced_pattern_en_o,
  .decision_walk_enable_o, .internal_test_voltage_route_o, .addr_i, .wdata_i, .rdata_o, .forced_pattern_o);

// file: test/acsd_host_model.sv
`timescale 1ns/10ps
module acsd_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
  end
  // one idle cycle between strobes keeps each driver edge single-assigned
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
  endtask
  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule

// file: test/adc_channel_select_diag_regs_test.sv
`timescale 1ns/10ps
module adc_channel_select_diag_regs_test;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, gate = 1'b0, wr, rd, vld, vr, bw;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] id;
  logic ov = 1'b0, pen;
  logic [2:0] oid = 3'h0;
  logic [7:0] role;
  logic [15:0] pat;
  int mismatches = 0, checked = 0;
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  acsd_host_model u_acsd_host_model (.mclk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  acsd_chan_diag u_acsd_chan_diag (.mclk_i, .rst_n_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .diagnostic_gate_i(gate), .otf_valid_i(ov), .otf_input_id_i(oid), .rdata_o(rdata), .conv_input_id_o(id),
    .conv_input_valid_o(vld), .pin_role_o(role), .internal_test_voltage_route_o(vr), .decision_walk_enable_o(bw),
    .forced_pattern_o(pat), .forced_pattern_en_o(pen));
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    u_acsd_host_model.rd(a, d);
    chk(16'(d), 16'(e));
  endtask
  // bounded wait, the dwell is eight cycles
  task wid(input logic [2:0] e);
    int n;
    n = 0;
    while (!(id === e && vld === 1'b1) && n < 12) begin
      @(posedge mclk_i);
      n++;
    end
    chk(16'(id), 16'(e));
  endtask
  task t_reset;
    logic [7:0] ad[7] = '{8'h11, 8'h12, 8'hbf, 8'hc0, 8'hc1, 8'hc2, 8'h77};
    foreach (ad[i]) rdc(ad[i], 8'h00);
  endtask
  task t_regs;
    u_acsd_host_model.wr(8'h12, 8'ha5);
    rdc(8'h12, 8'ha5);
    u_acsd_host_model.wr(8'h05, 8'h00);
    u_acsd_host_model.wr(8'h11, 8'hf6);
    rdc(8'h11, 8'h06);
    u_acsd_host_model.wr(8'h10, 8'h00);
    repeat (2) @(posedge mclk_i);
    chk(16'(id), 16'h0006);
    chk(16'(vld), 16'h0001);
    chk(16'(role), 16'h0000);
    u_acsd_host_model.wr(8'h10, 8'h03);
    repeat (2) @(posedge mclk_i);
    chk(16'(vld), 16'h0000);
  endtask
  task t_lock;
    u_acsd_host_model.wr(8'hbf, 8'h69);
    u_acsd_host_model.wr(8'hc0, 8'h11);
    rdc(8'hc0, 8'h00);
    u_acsd_host_model.wr(8'hbf, 8'h96);
    u_acsd_host_model.wr(8'hc0, 8'hff);
    rdc(8'hc0, 8'h11);
    chk(16'(bw), 16'h0001);
    chk(16'(vr), 16'h0000);
    u_acsd_host_model.wr(8'hc0, 8'h10);
    repeat (2) @(posedge mclk_i);
    chk(16'(vr), 16'h0001);
  endtask
  task t_forced;
    u_acsd_host_model.wr(8'hc1, 8'h34);
    u_acsd_host_model.wr(8'hc2, 8'h12);
    chk(pat, 16'h0000);
    chk(16'(pen), 16'h0000);
    @(posedge mclk_i);
    gate <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(pat, 16'h1234);
    chk(16'(pen), 16'h0001);
    gate <= 1'b0;
  endtask
  task t_otf;
    u_acsd_host_model.wr(8'h05, 8'h81);
    repeat (2) @(posedge mclk_i);
    chk(16'(role), 16'h0081);
    u_acsd_host_model.wr(8'h05, 8'h00);
    oid <= 3'h3;
    ov <= 1'b1;
    u_acsd_host_model.wr(8'h10, 8'h02);
    repeat (2) @(posedge mclk_i);
    chk(16'(id), 16'h0003);
    chk(16'(vld), 16'h0001);
    ov <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(16'(vld), 16'h0000);
  endtask
  task t_auto;
    u_acsd_host_model.wr(8'h12, 8'h24);
    u_acsd_host_model.wr(8'h10, 8'h11);
    wid(3'h2);
    wid(3'h5);
    rdc(8'h10, 8'h19);
    u_acsd_host_model.wr(8'h10, 8'h01);
    rdc(8'h10, 8'h01);
  endtask
  task stop_test;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset;
    t_regs;
    t_lock;
    t_forced;
    t_otf;
    t_auto;
    stop_test;
  end
  // hang guard, well past the expected run
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end
endmodule
